/* File: logic/cbds_pkg.sv */
// What this block does
// - Digits sent serially, leading to trailing
// - Digit code is positive-true 8-4-2-1
// - Direct path interval status code table
// - Prescaled path interval status code table
// - Result strobe 0.5-1.5 us, slow timebase
// - Result strobe 0.2-1.2 us, fast timebase
// - Strobe rises right after gate ends
// - Storage loads on strobe rising edge
// - Manual setting holds strobe high
// - Reset line idles high, driven by button/selector
// - Own internal clear never drives reset line
// - Disable high: internal 2 kHz clock out
// - Scan rising edge steps digit, one period
// - Slot pulse one scan period, ~4 ms cycle
// - Disable low: take external scan clock
// - External scan clock divided by eight
// - Active-low frame sync slot before leading digit
// - Active-high first digit slot with leading digit
// - Manual all-nines plus one count sets overflow
// - Gate overflow raises overflow output
package cbds_pkg;
  localparam int CLK_MHZ = 125;
  localparam longint SCAN_HALF_NS = 250000;
  localparam int SCAN_HALF_CYC = int'((SCAN_HALF_NS * CLK_MHZ) / 1000);
  localparam longint STROBE_SLOW_NS = 1000;
  localparam longint STROBE_FAST_NS = 500;
  localparam logic [7:0] STROBE_SLOW_CYC = 8'((STROBE_SLOW_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] STROBE_FAST_CYC = 8'((STROBE_FAST_NS * CLK_MHZ + 999) / 1000);
  localparam longint GATE_BASE_NS = 10000000;
  localparam int GATE_BASE_CYC = int'((GATE_BASE_NS * CLK_MHZ) / 1000);
  localparam int NUM_DIGITS = 7;
  localparam int SLOT_W = 3;
  localparam int EXT_DIV = 8;
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_COUNT = 8'h08;
  localparam int CTRL_W = 7;
  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_PRESCALE_BIT = 3;
  localparam int CTRL_FAST_BIT = 4;
  localparam int CTRL_BUTTON_BIT = 5;
  localparam int CTRL_MOVING_BIT = 6;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h02;
  localparam logic [2:0] SEL_MANUAL = 3'h4;
  localparam int STAT_OVF_BIT = 0;
  localparam int STAT_STROBE_BIT = 1;
  localparam int STAT_LINE_BIT = 2;
  localparam int STAT_SLOT_LSB = 3;
  typedef enum logic [1:0] {
    GS_GATE = 2'b01,
    GS_MANUAL = 2'b10
  } cbds_gate_t;
endpackage

/* File: logic/cbds_scan_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface cbds_scan_if;
  logic int_edge;
  logic ext_edge;
  logic use_ext;
  logic [cbds_pkg::SLOT_W-1:0] slot;
  modport seq (input int_edge, input ext_edge, input use_ext, output slot);
  modport ctl (output int_edge, output ext_edge, output use_ext, input slot);
endinterface
`default_nettype wire

/* File: logic/cbds_slot_seq.sv */
`timescale 1ns/1ps
`default_nettype none
module cbds_slot_seq (
  input wire logic i_clk,   // System clock
  input wire logic i_rst_n, // Synchronised reset
  cbds_scan_if.seq scan     // Scan edges in, slot out
);
  localparam int DIV_W = $clog2(cbds_pkg::EXT_DIV);
  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic [cbds_pkg::SLOT_W-1:0] slot;
  } cbds_seq_t;
  cbds_seq_t st;
  cbds_seq_t nx;
  logic step;

  always_comb
  begin
    nx = st;
    step = 1'b0;
    if (scan.use_ext)
    begin
      if (scan.ext_edge)
      begin
        nx.div = st.div + DIV_W'(1);
        step = (st.div == DIV_W'(cbds_pkg::EXT_DIV - 1));
      end
    end
    else
    begin
      nx.div = '0;
      step = scan.int_edge;
    end
    if (step)
    begin
      nx.slot = st.slot + cbds_pkg::SLOT_W'(1);
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= nx;
    end
  end

  assign scan.slot = st.slot;
endmodule
`default_nettype wire

/* File: logic/cbds_top.sv */
`timescale 1ns/1ps
`default_nettype none
module cbds_top #(
  parameter int unsigned GATE_BASE_CYCLES = cbds_pkg::GATE_BASE_CYC,
  parameter int unsigned SCAN_HALF_CYCLES = cbds_pkg::SCAN_HALF_CYC,
  parameter int NUM_DIGITS = cbds_pkg::NUM_DIGITS
) (
  input wire logic I_MCLK,                          // 125 MHz clock
  input wire logic I_ARST_N,                        // Async reset, low
  input wire logic I_PSEL,                          // APB select
  input wire logic I_PENABLE,                       // APB enable
  input wire logic I_PWRITE,                        // APB write
  input wire logic [cbds_pkg::ADDR_W-1:0] I_PADDR,  // APB address
  input wire logic [31:0] I_PWDATA,                 // APB write data
  output logic [31:0] O_PRDATA,                     // APB read data
  output logic O_PREADY,                            // APB ready
  output logic O_PSLVERR,                           // APB error
  input wire logic I_COUNT_IN,                      // Signal to count
  input wire logic I_SCAN_DISABLE,                  // High: internal scan
  input wire logic I_EXT_SCAN_CLK,                  // External scan clock
  input wire logic I_RESET_LINE,                    // Reset line level
  output logic O_RESET_LINE,                        // Reset line drive
  output logic O_RESET_LINE_OE,                     // Reset line enable
  output logic O_SCAN_CLK,                          // Internal scan clock
  output logic [3:0] O_BCD,                         // Digit code
  output logic O_FRAME_SYNC_SLOT_N,                 // Frame sync, low
  output logic O_FIRST_DIGIT_SLOT,                  // Leading digit slot
  output logic O_RESULT_VALID,                      // Result strobe
  output logic O_OVERFLOW,                          // Overflow
  output logic [1:0] O_STATUS                       // Interval status
);
  localparam int CW = 4 * NUM_DIGITS;
  localparam int GU_W = $clog2(GATE_BASE_CYCLES + 1);
  localparam int SH_W = $clog2(SCAN_HALF_CYCLES + 1);
  localparam logic [GU_W-1:0] GU_LAST = GU_W'(GATE_BASE_CYCLES - 1);
  localparam logic [SH_W-1:0] SH_LAST = SH_W'(SCAN_HALF_CYCLES - 1);

  typedef struct packed {
    logic [2:0] cnt_sync;
    logic [2:0] line_sync;
    logic [2:0] ext_sync;
    logic [2:0] dis_sync;
    logic cnt_f;
    logic line_f;
    logic ext_f;
    logic dis_f;
    logic cnt_fd;
    logic ext_fd;
    logic [cbds_pkg::CTRL_W-1:0] ctrl;
    cbds_pkg::cbds_gate_t gstate;
    logic [CW-1:0] cnt;
    logic [CW-1:0] store;
    logic run_ovf;
    logic ovf;
    logic [GU_W-1:0] gate_unit;
    logic [9:0] dec;
    logic [7:0] strobe_cnt;
    logic strobe;
    logic [SH_W-1:0] scan_div;
    logic scan_clk;
    logic [3:0] bcd;
    logic fs_n;
    logic fd;
    logic [1:0] status;
  } cbds_state_t;

  cbds_state_t st;
  cbds_state_t nx;
  logic [1:0] rst_sync;
  logic rst_n;
  logic [CW:0] inc;
  logic cnt_edge;
  logic gate_end;
  logic [2:0] sel;
  logic manual;
  logic drive_low;
  logic wr_ctrl;
  logic mapped;
  cbds_scan_if scan ();

  function automatic logic [CW:0] bcd_inc(input logic [CW-1:0] v);
    logic [CW-1:0] r;
    logic c;
    r = v;
    c = 1'b1;
    for (int i = 0; i < NUM_DIGITS; i++)
    begin
      if (c)
      begin
        if (r[4*i +: 4] == 4'h9)
        begin
          r[4*i +: 4] = 4'h0;
        end
        else
        begin
          r[4*i +: 4] = r[4*i +: 4] + 4'h1;
          c = 1'b0;
        end
      end
    end
    return {c, r};
  endfunction

  // Status pair {first, second}; the two input paths differ per interval
  function automatic logic [1:0] status_code(input logic [2:0] s, input logic pre);
    logic [1:0] r;
    r = 2'b11;
    if (!pre)
    begin
      case (s)
        3'h0: r = 2'b00;
        3'h1: r = 2'b10;
        3'h2: r = 2'b11;
        3'h3: r = 2'b01;
        default: r = 2'b11;
      endcase
    end
    else
    begin
      case (s)
        3'h0: r = 2'b10;
        3'h1: r = 2'b00;
        3'h2: r = 2'b10;
        3'h3: r = 2'b11;
        default: r = 2'b11;
      endcase
    end
    return r;
  endfunction

  function automatic logic [9:0] dec_last(input logic [2:0] s);
    logic [9:0] r;
    case (s)
      3'h0: r = 10'h000;
      3'h1: r = 10'h009;
      3'h2: r = 10'h063;
      default: r = 10'h3E7;
    endcase
    return r;
  endfunction

  // Reset release through two flops
  always_ff @(posedge I_MCLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
    begin
      rst_sync <= 2'b00;
    end
    else
    begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  assign sel = st.ctrl[cbds_pkg::CTRL_SEL_LSB +: 3];
  assign manual = (sel >= cbds_pkg::SEL_MANUAL);
  assign cnt_edge = st.cnt_f & ~st.cnt_fd;
  assign inc = bcd_inc(st.cnt);
  assign gate_end = (st.gstate == cbds_pkg::GS_GATE) && (st.gate_unit == GU_LAST)
                    && (st.dec == dec_last(sel));
  assign drive_low = st.ctrl[cbds_pkg::CTRL_BUTTON_BIT]
                     | st.ctrl[cbds_pkg::CTRL_MOVING_BIT];
  assign mapped = (I_PADDR == cbds_pkg::REG_CTRL) || (I_PADDR == cbds_pkg::REG_STAT)
                  || (I_PADDR == cbds_pkg::REG_COUNT);
  assign wr_ctrl = I_PSEL & I_PENABLE & I_PWRITE & (I_PADDR == cbds_pkg::REG_CTRL);

  assign scan.use_ext = ~st.dis_f;
  assign scan.ext_edge = st.ext_f & ~st.ext_fd;
  assign scan.int_edge = st.dis_f & (st.scan_div == SH_LAST) & ~st.scan_clk;

  always_comb
  begin
    nx = st;
    // Pin inputs: level moves once the last two flops agree
    nx.cnt_sync = {st.cnt_sync[1:0], I_COUNT_IN};
    nx.line_sync = {st.line_sync[1:0], I_RESET_LINE};
    nx.ext_sync = {st.ext_sync[1:0], I_EXT_SCAN_CLK};
    nx.dis_sync = {st.dis_sync[1:0], I_SCAN_DISABLE};
    if (st.cnt_sync[1] == st.cnt_sync[2])
    begin
      nx.cnt_f = st.cnt_sync[2];
    end
    if (st.line_sync[1] == st.line_sync[2])
    begin
      nx.line_f = st.line_sync[2];
    end
    if (st.ext_sync[1] == st.ext_sync[2])
    begin
      nx.ext_f = st.ext_sync[2];
    end
    if (st.dis_sync[1] == st.dis_sync[2])
    begin
      nx.dis_f = st.dis_sync[2];
    end
    nx.cnt_fd = st.cnt_f;
    nx.ext_fd = st.ext_f;

    if (wr_ctrl)
    begin
      nx.ctrl = I_PWDATA[cbds_pkg::CTRL_W-1:0];
    end

    // Internal scan clock; frozen low while the far side supplies one
    if (st.dis_f)
    begin
      if (st.scan_div == SH_LAST)
      begin
        nx.scan_div = '0;
        nx.scan_clk = ~st.scan_clk;
      end
      else
      begin
        nx.scan_div = st.scan_div + SH_W'(1);
      end
    end
    else
    begin
      nx.scan_div = '0;
      nx.scan_clk = 1'b0;
    end

    // Counting chain
    nx.gstate = manual ? cbds_pkg::GS_MANUAL : cbds_pkg::GS_GATE;
    if (cnt_edge)
    begin
      nx.cnt = inc[CW-1:0];
      if (inc[CW])
      begin
        if (st.gstate == cbds_pkg::GS_MANUAL)
        begin
          nx.ovf = 1'b1;
        end
        else
        begin
          nx.run_ovf = 1'b1;
        end
      end
    end

    if (st.strobe_cnt != 8'h00)
    begin
      nx.strobe_cnt = st.strobe_cnt - 8'h01;
    end
    nx.strobe = (nx.strobe_cnt != 8'h00);

    case (st.gstate)
      cbds_pkg::GS_GATE:
      begin
        if (st.gate_unit == GU_LAST)
        begin
          nx.gate_unit = '0;
          nx.dec = st.dec + 10'h001;
        end
        else
        begin
          nx.gate_unit = st.gate_unit + GU_W'(1);
        end
        if (gate_end)
        begin
          // Internal clear for the next count; reset line untouched
          nx.store = nx.cnt;
          nx.ovf = nx.run_ovf;
          nx.cnt = '0;
          nx.run_ovf = 1'b0;
          nx.dec = '0;
          nx.strobe_cnt = st.ctrl[cbds_pkg::CTRL_FAST_BIT] ?
                          cbds_pkg::STROBE_FAST_CYC : cbds_pkg::STROBE_SLOW_CYC;
          nx.strobe = 1'b1;
        end
        if (manual)
        begin
          nx.gate_unit = '0;
          nx.dec = '0;
        end
      end
      cbds_pkg::GS_MANUAL:
      begin
        // Running total shown live, so the strobe stays up
        nx.store = nx.cnt;
        nx.strobe = 1'b1;
        nx.strobe_cnt = 8'h00;
        if (!manual)
        begin
          nx.cnt = '0;
          nx.run_ovf = 1'b0;
          nx.strobe = 1'b0;
        end
      end
      default:
      begin
        nx.gstate = cbds_pkg::GS_GATE;
      end
    endcase

    // Low reset line, from us or the far side, clears the counter
    if (!st.line_f)
    begin
      nx.cnt = '0;
      nx.store = '0;
      nx.ovf = 1'b0;
      nx.run_ovf = 1'b0;
      nx.gate_unit = '0;
      nx.dec = '0;
      nx.strobe_cnt = 8'h00;
      nx.strobe = manual;
    end

    // Scan outputs: slot 0 is sync, slots 1..N carry digits
    nx.fs_n = (scan.slot != '0);
    nx.fd = (scan.slot == cbds_pkg::SLOT_W'(1));
    if ((scan.slot == '0) || (int'(scan.slot) > NUM_DIGITS))
    begin
      nx.bcd = 4'h0;
    end
    else
    begin
      nx.bcd = st.store[4*(NUM_DIGITS - int'(scan.slot)) +: 4];
    end
    nx.status = status_code(sel, st.ctrl[cbds_pkg::CTRL_PRESCALE_BIT]);
  end

  always_ff @(posedge I_MCLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '0;
      st.ctrl <= cbds_pkg::CTRL_RESET;
      st.gstate <= cbds_pkg::GS_GATE;
      st.line_sync <= 3'h7;
      st.line_f <= 1'b1;
      st.dis_sync <= 3'h7;
      st.dis_f <= 1'b1;
      st.fs_n <= 1'b1;
    end
    else
    begin
      st <= nx;
    end
  end

  cbds_slot_seq u_seq (
    .i_clk(I_MCLK),
    .i_rst_n(rst_n),
    .scan(scan.seq)
  );

  // Zero-wait slave; read data muxed straight from state flops
  always_comb
  begin
    O_PRDATA = 32'h0000_0000;
    if (I_PSEL && !I_PWRITE)
    begin
      if (I_PADDR == cbds_pkg::REG_CTRL)
      begin
        O_PRDATA[cbds_pkg::CTRL_W-1:0] = st.ctrl;
      end
      else if (I_PADDR == cbds_pkg::REG_STAT)
      begin
        O_PRDATA[cbds_pkg::STAT_OVF_BIT] = st.ovf;
        O_PRDATA[cbds_pkg::STAT_STROBE_BIT] = st.strobe;
        O_PRDATA[cbds_pkg::STAT_LINE_BIT] = st.line_f;
        O_PRDATA[cbds_pkg::STAT_SLOT_LSB +: cbds_pkg::SLOT_W] = scan.slot;
      end
      else if (I_PADDR == cbds_pkg::REG_COUNT)
      begin
        O_PRDATA[CW-1:0] = st.store;
      end
    end
  end
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = I_PSEL & I_PENABLE & (~mapped | (I_PWRITE & ~wr_ctrl));

  // Open drain: never driven high
  assign O_RESET_LINE = 1'b0;
  assign O_RESET_LINE_OE = drive_low;
  assign O_SCAN_CLK = st.scan_clk;
  assign O_BCD = st.bcd;
  assign O_FRAME_SYNC_SLOT_N = st.fs_n;
  assign O_FIRST_DIGIT_SLOT = st.fd;
  assign O_RESULT_VALID = st.strobe;
  assign O_OVERFLOW = st.ovf;
  assign O_STATUS = st.status;
endmodule
`default_nettype wire

/* File: tb/cbds_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module cbds_properties #(
  parameter int unsigned SCAN_HALF_CYCLES = 8
) (
  input wire logic I_MCLK, // Clock
  input wire logic I_ARST_N, // Reset
  input wire logic I_PSEL, // Select
  input wire logic I_PENABLE, // Enable
  input wire logic I_PWRITE, // Write
  input wire logic I_SCAN_DISABLE, // Scan disable
  input wire logic O_RESET_LINE, // Line drive
  input wire logic O_RESET_LINE_OE, // Line enable
  input wire logic O_SCAN_CLK, // Scan clock
  input wire logic [3:0] O_BCD, // Digit
  input wire logic O_FRAME_SYNC_SLOT_N, // Sync slot
  input wire logic O_FIRST_DIGIT_SLOT, // First slot
  input wire logic O_RESULT_VALID // Strobe
);
  typedef struct packed {
    logic last;
    logic [3:0] ns;
    logic [7:0] sh;
    logic [7:0] fl;
    logic [7:0] dh;
    logic [15:0] vh;
  } cbds_chk_t;
  cbds_chk_t st;
  cbds_chk_t next_st;
  logic wr;
  assign wr = I_PSEL && I_PENABLE && I_PWRITE;
  // Run lengths; ns saturates so only a settled internal clock is trusted
  always_comb
  begin
    next_st.last = O_SCAN_CLK;
    next_st.sh = (O_SCAN_CLK != st.last) ? 8'h01 : st.sh + 8'h01;
    next_st.ns = !I_SCAN_DISABLE ? 4'h0 : st.ns + 4'((O_SCAN_CLK != st.last) && st.ns != 4'hF);
    next_st.fl = O_FRAME_SYNC_SLOT_N ? 8'h00 : st.fl + 8'h01;
    next_st.dh = O_FIRST_DIGIT_SLOT ? st.dh + 8'h01 : 8'h00;
    next_st.vh = O_RESULT_VALID ? st.vh + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge I_MCLK or negedge I_ARST_N)
  begin
    if (!I_ARST_N)
      st <= '0;
    else
      st <= next_st;
  end
  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (!I_ARST_N);
  a_line_never_high: assert property (!O_RESET_LINE)
    else $error("reset line driven high");
  a_oe_from_write: assert property ($changed(O_RESET_LINE_OE) |-> $past(wr) || $past(wr, 2))
    else $error("line enable moved without a write");
  a_strobe_width: assert property ($fell(O_RESULT_VALID) |-> st.vh >= 16'd25 && st.vh <= 16'd187)
    else $error("strobe width out of range");
  a_scan_half: assert property (O_SCAN_CLK != st.last && st.ns >= 4'h1 |-> st.sh == 8'(SCAN_HALF_CYCLES))
    else $error("scan half period wrong");
  a_ext_stops_int: assert property (!I_SCAN_DISABLE [*8] |=> !O_SCAN_CLK)
    else $error("internal scan clock runs while disabled");
  a_sync_slot_alone: assert property (!O_FRAME_SYNC_SLOT_N |-> !O_FIRST_DIGIT_SLOT && O_BCD == 4'h0)
    else $error("sync slot overlaps digit slot");
  a_sync_then_first: assert property ($rose(O_FRAME_SYNC_SLOT_N) |-> O_FIRST_DIGIT_SLOT)
    else $error("first digit slot does not follow sync");
  a_sync_width: assert property ($rose(O_FRAME_SYNC_SLOT_N) && st.ns == 4'hF |-> st.fl == 8'(2 * SCAN_HALF_CYCLES))
    else $error("sync slot width wrong");
  a_first_width: assert property ($fell(O_FIRST_DIGIT_SLOT) && st.ns == 4'hF |-> st.dh == 8'(2 * SCAN_HALF_CYCLES))
    else $error("first slot width wrong");
  a_digit_bcd: assert property (O_BCD <= 4'h9)
    else $error("digit code above nine");
  cover property ($rose(O_RESULT_VALID));
  cover property ($fell(O_FRAME_SYNC_SLOT_N) && !I_SCAN_DISABLE);
  cover property ($rose(O_RESET_LINE_OE));
endmodule
bind cbds_top cbds_properties #(.SCAN_HALF_CYCLES(SCAN_HALF_CYCLES)) u_props (
  .I_MCLK(I_MCLK), .I_ARST_N(I_ARST_N), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
  .I_PWRITE(I_PWRITE), .I_SCAN_DISABLE(I_SCAN_DISABLE), .O_RESET_LINE(O_RESET_LINE),
  .O_RESET_LINE_OE(O_RESET_LINE_OE), .O_SCAN_CLK(O_SCAN_CLK), .O_BCD(O_BCD),
  .O_FRAME_SYNC_SLOT_N(O_FRAME_SYNC_SLOT_N), .O_FIRST_DIGIT_SLOT(O_FIRST_DIGIT_SLOT),
  .O_RESULT_VALID(O_RESULT_VALID));
`default_nettype wire

/* File: tb/cbds_scan_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module cbds_scan_partner (
  input wire logic i_clk, // Bench clock
  input wire logic i_use_ext, // Run own scan clock
  input wire logic i_pull, // Reset request
  input wire logic i_scan_clk, // Internal scan clock
  input wire logic [3:0] i_bcd, // Digit lines
  input wire logic i_sync_n, // Frame sync
  output logic o_disable, // Scan disable
  output logic o_ext_clk, // External scan clock
  output logic o_pull_low, // Open-drain pull
  output logic [27:0] o_value, // Last frame
  output int o_frames // Frames seen
);
  int k = 56;
  int per;
  int t = 0;
  logic [27:0] val = '0;
  logic clk_a;
  initial
  begin
    o_ext_clk = 1'b0;
    o_value = '0;
    o_frames = 0;
  end
  assign o_disable = !i_use_ext;
  assign o_pull_low = i_pull;
  assign per = i_use_ext ? 8 : 1;
  assign clk_a = i_use_ext ? o_ext_clk : i_scan_clk;
  // 128-cycle period keeps it under 1 MHz; stands low when not in use
  always @(posedge i_clk)
  begin
    t <= i_use_ext ? t + 1 : 0;
    o_ext_clk <= i_use_ext && t[6];
  end
  always @(negedge clk_a)
  begin
    if (!i_sync_n)
      k = 0;
    else if (k < 7 * per)
    begin
      k = k + 1;
      if (k % per == 0)
        val[27 - 4 * (k / per - 1) -: 4] = i_bcd;
      if (k == 7 * per)
      begin
        o_value = val;
        o_frames = o_frames + 1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/cbds_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module cbds_top_tb;
  logic clk, arst_n, psel, pen, pwr, cnt_in, use_ext, pull, pready, pslverr, e;
  logic dis, ext_clk, pull_low, line, line_o, oe, scan_clk, fs_n, first, rv, ovf;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0] bcd;
  logic [1:0] status;
  logic [27:0] value;
  logic [1:0] stab [10] = '{2'h0, 2'h2, 2'h3, 2'h1, 2'h3, 2'h2, 2'h0, 2'h2, 2'h3, 2'h3};
  int frames, w;
  int bad_count = 0;
  int samples_checked = 0;
  assign line = !(oe || pull_low);
  cbds_top #(.GATE_BASE_CYCLES(200), .SCAN_HALF_CYCLES(8)) DUT (
    .I_MCLK(clk), .I_ARST_N(arst_n), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_COUNT_IN(cnt_in), .I_SCAN_DISABLE(dis), .I_EXT_SCAN_CLK(ext_clk),
    .I_RESET_LINE(line), .O_RESET_LINE(line_o), .O_RESET_LINE_OE(oe), .O_SCAN_CLK(scan_clk),
    .O_BCD(bcd), .O_FRAME_SYNC_SLOT_N(fs_n), .O_FIRST_DIGIT_SLOT(first),
    .O_RESULT_VALID(rv), .O_OVERFLOW(ovf), .O_STATUS(status));
  cbds_scan_partner u_far (.i_clk(clk), .i_use_ext(use_ext), .i_pull(pull),
    .i_scan_clk(scan_clk), .i_bcd(bcd), .i_sync_n(fs_n), .o_disable(dis), .o_ext_clk(ext_clk),
    .o_pull_low(pull_low), .o_value(value), .o_frames(frames));
  task automatic end_of_test();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic give_up();
    bad_count++;
    end_of_test();
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wt, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= wt;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (n > 50)
        give_up();
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic xe);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
    chk(32'(e), 32'(xe));
  endtask
  task automatic wait_rv(input int lim);
    logic p;
    int n;
    p = rv;
    n = 0;
    while (!(rv === 1'b1 && p === 1'b0))
    begin
      p = rv;
      @(posedge clk);
      n++;
      if (n > lim)
        give_up();
    end
  endtask
  task automatic strobe_len(input logic [31:0] exp);
    w = 0;
    while (rv === 1'b1 && w < 400)
    begin
      w++;
      @(posedge clk);
    end
    chk(32'(w), exp);
  endtask
  task automatic wait_frames(input int m, input int lim);
    int f;
    int n;
    f = frames + m;
    for (n = 0; frames < f; n++)
    begin
      @(posedge clk);
      if (n > lim)
        give_up();
    end
  endtask
  task automatic pulses(input int n);
    repeat (n)
    begin
      cnt_in <= 1'b1;
      repeat (4) @(posedge clk);
      cnt_in <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial
  begin
    arst_n = 1'b0;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cnt_in = 1'b0;
    use_ext = 1'b0;
    pull = 1'b0;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(8'h00, 32'h02, 1'b0);
    rd(8'h0C, 32'h0, 1'b1);
    apb(1'b1, 8'h04, 32'hFF);
    chk(32'(e), 32'h1);
    chk(32'(ovf), 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b1, 8'h00, 32'((i / 4) * 8 + i % 4));
      repeat (4) @(posedge clk);
      chk(32'(status), 32'(stab[(i / 4) * 5 + i % 4]));
    end
    apb(1'b1, 8'h00, 32'h10);
    wait_rv(2000);
    strobe_len(32'd63);
    for (int i = 0; i < 2; i++)
    begin
      apb(1'b1, 8'h00, 32'h02 | (32'h20 << i));
      repeat (3) @(posedge clk);
      chk(32'(oe), 32'h1);
      chk(32'(line), 32'h0);
    end
    apb(1'b1, 8'h00, 32'h02);
    wait_rv(25000);
    pulses(19);
    wait_rv(25000);
    strobe_len(32'd125);
    rd(8'h08, 32'h19, 1'b0);
    chk(32'(oe), 32'h0);
    // Long gate so the storage cannot reload while slow frames are scanned
    apb(1'b1, 8'h00, 32'h03);
    wait_frames(2, 1000);
    chk(32'(value), 32'h19);
    use_ext <= 1'b1;
    // Up to a full frame to reach sync, then two 8192-cycle frames
    wait_frames(2, 26000);
    chk(32'(scan_clk), 32'h0);
    chk(32'(value), 32'h19);
    use_ext <= 1'b0;
    pull <= 1'b1;
    repeat (10) @(posedge clk);
    rd(8'h08, 32'h0, 1'b0);
    chk(32'(oe), 32'h0);
    pull <= 1'b0;
    apb(1'b1, 8'h00, 32'h04);
    repeat (10) @(posedge clk);
    chk(32'(rv), 32'h1);
    chk(32'(status), 32'(stab[4]));
    pulses(3);
    repeat (10) @(posedge clk);
    rd(8'h08, 32'h3, 1'b0);
    apb(1'b1, 8'h00, 32'h0C);
    repeat (4) @(posedge clk);
    chk(32'(status), 32'(stab[9]));
    chk(32'(ovf), 32'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
